//--- src/ccd_consts.vh
/*
 * Constants of the chop and current-detect configuration block: register
 * indices, field positions, reset values and window lengths.
 * Assumes inclusion by bare name from the design files of this block only.
 */
`ifndef CCD_CONSTS_VH
`define CCD_CONSTS_VH

// ----------------------------------------------------------------
// Register indices (plain port, word addressed)
// ----------------------------------------------------------------
`define CCD_OFS_GAIN_HI 8'h05
`define CCD_OFS_CFG 8'h06
`define CCD_OFS_THR_HI 8'h07
`define CCD_OFS_THR_LO 8'h08
`define CCD_OFS_IRQ_STAT 8'h10
`define CCD_OFS_IRQ_EN 8'h11
`define CCD_OFS_IRQ_CLR 8'h12
`define CCD_OFS_DET_STAT 8'h13

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CCD_RST_GAIN_HI 16'h0000
`define CCD_RST_CFG 16'h0600
`define CCD_RST_THR 16'h0000
`define CCD_RST_IRQ 3'h0
`define CCD_RST_THR_LO 8'h00
`define CCD_RST_DCB 4'h0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CCD_GAIN4_MSB 2
`define CCD_GAIN4_LSB 0
`define CCD_CFG_DLY_MSB 12
`define CCD_CFG_DLY_LSB 9
`define CCD_CFG_CHOP_EN 8
`define CCD_CFG_ALLCH 7
`define CCD_CFG_NUM_MSB 6
`define CCD_CFG_NUM_LSB 4
`define CCD_CFG_LEN_MSB 3
`define CCD_CFG_LEN_LSB 1
`define CCD_CFG_DET_EN 0
`define CCD_THR_LO_MSB 15
`define CCD_THR_LO_LSB 8
`define CCD_DCB_MSB 3
`define CCD_DCB_LSB 0
`define CCD_IRQ_DETECT 0
`define CCD_IRQ_WINDOW 1
`define CCD_IRQ_SETTLE 2

// ----------------------------------------------------------------
// Counts
// ----------------------------------------------------------------
`define CCD_CHOP_BASE 17'h00002
`define CCD_WIN_LEN0 12'h080
`define CCD_WIN_LEN1 12'h100
`define CCD_WIN_LEN2 12'h200
`define CCD_WIN_LEN3 12'h300
`define CCD_WIN_LEN4 12'h500
`define CCD_WIN_LEN5 12'h700
`define CCD_WIN_LEN6 12'ha00
`define CCD_WIN_LEN7 12'he00
`define CCD_NUM_BASE 9'h001

`endif

//--- src/ccd_chop_delay.v
/*
 * Global-chop settling delay: after a measurement request, waits the
 * selected number of modulator clock periods before starting.
 * Assumes mod_tick is a one-cycle strobe per modulator clock period.
 */
`include "ccd_consts.vh"

module ccd_chop_delay (
    input wire core_clk,
    input wire rst_n,
    input wire ce,
    input wire chop_en,
    input wire [3:0] dly_sel,
    input wire meas_req,
    input wire mod_tick,
    output reg meas_start_r,
    output reg settling_r
);

    localparam ST_IDLE = 1'b0;
    localparam ST_WAIT = 1'b1;

    reg state_r;
    reg [16:0] cnt_r;
    reg [16:0] target_r;

    // ----------------------------------------------------------------
    // Settle sequencer
    // ----------------------------------------------------------------
    always @(posedge core_clk) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            cnt_r <= 17'h00000;
            target_r <= 17'h00000;
            meas_start_r <= 1'b0;
            settling_r <= 1'b0;
        end else if (ce) begin
            meas_start_r <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (meas_req) begin
                        if (chop_en) begin
                            target_r <= `CCD_CHOP_BASE << dly_sel;
                            cnt_r <= 17'h00000;
                            settling_r <= 1'b1;
                            state_r <= ST_WAIT;
                        end else begin
                            meas_start_r <= 1'b1;
                        end
                    end
                end
                ST_WAIT: begin
                    // Requests during the wait are absorbed, not queued
                    if (mod_tick) begin
                        if (cnt_r + 17'h00001 == target_r) begin
                            meas_start_r <= 1'b1;
                            settling_r <= 1'b0;
                            state_r <= ST_IDLE;
                        end else begin
                            cnt_r <= cnt_r + 17'h00001;
                        end
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    settling_r <= 1'b0;
                end
            endcase
        end
    end

endmodule // ccd_chop_delay

//--- src/ccd_detect_win.v
/*
 * Current-detect measurement window: counts conversion periods and
 * threshold exceedances, flags a detection and the end of each window.
 * Assumes conv_valid is a one-cycle strobe per conversion period.
 */
`include "ccd_consts.vh"

module ccd_detect_win (
    input wire core_clk,
    input wire rst_n,
    input wire ce,
    input wire enable,
    input wire [2:0] len_sel,
    input wire [2:0] num_sel,
    input wire conv_valid,
    input wire hit,
    output reg detect_r,
    output reg window_done_r,
    output reg [8:0] exceed_cnt_r,
    output reg [11:0] window_cnt_r
);

    reg [11:0] win_len;
    wire [8:0] need = `CCD_NUM_BASE << num_sel;
    wire [8:0] exc_inc = exceed_cnt_r + 9'h001;
    wire last_conv = (window_cnt_r + 12'h001) == win_len;

    always @* begin
        case (len_sel)
            3'h0: win_len = `CCD_WIN_LEN0;
            3'h1: win_len = `CCD_WIN_LEN1;
            3'h2: win_len = `CCD_WIN_LEN2;
            3'h3: win_len = `CCD_WIN_LEN3;
            3'h4: win_len = `CCD_WIN_LEN4;
            3'h5: win_len = `CCD_WIN_LEN5;
            3'h6: win_len = `CCD_WIN_LEN6;
            default: win_len = `CCD_WIN_LEN7;
        endcase
    end

    // ----------------------------------------------------------------
    // Window and exceedance counters
    // ----------------------------------------------------------------
    always @(posedge core_clk) begin
        if (!rst_n) begin
            detect_r <= 1'b0;
            window_done_r <= 1'b0;
            exceed_cnt_r <= 9'h000;
            window_cnt_r <= 12'h000;
        end else if (ce) begin
            detect_r <= 1'b0;
            window_done_r <= 1'b0;
            if (!enable) begin
                exceed_cnt_r <= 9'h000;
                window_cnt_r <= 12'h000;
            end else if (conv_valid) begin
                // One detection per window: the count stops at the target
                if (hit && exceed_cnt_r != need) begin
                    exceed_cnt_r <= exc_inc;
                    if (exc_inc == need) begin
                        detect_r <= 1'b1;
                    end
                end
                if (last_conv) begin
                    window_done_r <= 1'b1;
                    window_cnt_r <= 12'h000;
                    exceed_cnt_r <= 9'h000;
                end else begin
                    window_cnt_r <= window_cnt_r + 12'h001;
                end
            end
        end
    end

endmodule // ccd_detect_win

//--- src/ccd_cfg_top.v
/*
 * Chop and current-detect configuration block: register file for the
 * upper gain word, the global configuration word and the detect
 * threshold, plus the chop settle and current-detect logic they steer.
 * Assumes a single 200 MHz core clock, channel results and strobes
 * synchronous to it, and a register master that never waits.
 */
// The plain strobed port was chosen for this implementation.
`include "ccd_consts.vh"

// How it works
// - Gain code 000b..111b of channel 4 selects amplifier gain 1 to 128.
// - Configuration word sits at index 06h and resets to 0600h.
// - With chop on, wait 2 to 65536 modulator periods before measuring.
// - Bit 7 low: any channel exceeding triggers; high: all channels must.
// - Detection declared after 1 to 128 exceedances, chosen by bits 6:4.
// - Window lasts 128 to 3584 conversion periods, chosen by bits 3:1.
// - Current-detect runs only while bit 0 is set; off after reset.
// - Results compared with a 24-bit signed threshold split over two registers.
// - Upper gain register holding channels 4 to 7 sits at index 5h.
module ccd_cfg_top (
    input wire core_clk,
    input wire rst_n,
    input wire ce,
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata_r,
    input wire mod_tick,
    input wire meas_req,
    input wire conv_valid,
    input wire [191:0] ch_data,
    output reg [2:0] ch4_gain_sel_r,
    output reg [7:0] ch4_gain_factor_r,
    output wire [15:0] upper_channel_gain,
    output wire chop_enable,
    output wire [3:0] chop_settle_delay,
    output wire detect_all_channels,
    output wire [2:0] detect_exceed_count,
    output wire [2:0] detect_window_length,
    output wire detect_mode_enable,
    output wire [3:0] dc_block_sel,
    output wire meas_start,
    output wire settling,
    output wire detect_pulse,
    output wire window_done,
    output wire irq
);

    localparam NCH = 8;
    localparam SW = 24;

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    reg [15:0] upper_channel_gain_r;
    reg [15:0] global_chop_detect_config_r;
    reg [15:0] detect_threshold_hi_r;
    reg [7:0] detect_threshold_lo_r;
    reg [3:0] dc_block_r;
    reg [2:0] irq_stat_r;
    reg [2:0] irq_en_r;
    reg [2:0] irq_stat_nxt;
    reg [15:0] rdata_nxt;

    wire [23:0] threshold;
    wire [NCH-1:0] exceed;
    wire any_hit;
    wire all_hit;
    wire hit;
    wire [2:0] events;
    wire [8:0] exceed_cnt;

    wire wr_gain = reg_wr && (reg_addr == `CCD_OFS_GAIN_HI);
    wire wr_cfg = reg_wr && (reg_addr == `CCD_OFS_CFG);
    wire wr_thr_hi = reg_wr && (reg_addr == `CCD_OFS_THR_HI);
    wire wr_thr_lo = reg_wr && (reg_addr == `CCD_OFS_THR_LO);
    wire wr_irq_en = reg_wr && (reg_addr == `CCD_OFS_IRQ_EN);
    wire wr_irq_clr = reg_wr && (reg_addr == `CCD_OFS_IRQ_CLR);

    // Reserved bits of the gain and config words are stored as written; the host keeps them zero
    always @(posedge core_clk) begin
        if (!rst_n) begin
            upper_channel_gain_r <= `CCD_RST_GAIN_HI;
            global_chop_detect_config_r <= `CCD_RST_CFG;
            detect_threshold_hi_r <= `CCD_RST_THR;
            detect_threshold_lo_r <= `CCD_RST_THR_LO;
            dc_block_r <= `CCD_RST_DCB;
        end else if (ce) begin
            if (wr_gain) begin
                upper_channel_gain_r <= reg_wdata;
            end
            if (wr_cfg) begin
                global_chop_detect_config_r <= reg_wdata;
            end
            if (wr_thr_hi) begin
                detect_threshold_hi_r <= reg_wdata;
            end
            if (wr_thr_lo) begin
                detect_threshold_lo_r <= reg_wdata[`CCD_THR_LO_MSB:`CCD_THR_LO_LSB];
                dc_block_r <= reg_wdata[`CCD_DCB_MSB:`CCD_DCB_LSB];
            end
        end
    end

    // ----------------------------------------------------------------
    // Field outputs
    // ----------------------------------------------------------------
    assign upper_channel_gain = upper_channel_gain_r;
    assign chop_enable = global_chop_detect_config_r[`CCD_CFG_CHOP_EN];
    assign chop_settle_delay = global_chop_detect_config_r[`CCD_CFG_DLY_MSB:`CCD_CFG_DLY_LSB];
    assign detect_all_channels = global_chop_detect_config_r[`CCD_CFG_ALLCH];
    assign detect_exceed_count = global_chop_detect_config_r[`CCD_CFG_NUM_MSB:`CCD_CFG_NUM_LSB];
    assign detect_window_length = global_chop_detect_config_r[`CCD_CFG_LEN_MSB:`CCD_CFG_LEN_LSB];
    assign detect_mode_enable = global_chop_detect_config_r[`CCD_CFG_DET_EN];
    assign dc_block_sel = dc_block_r;

    // ----------------------------------------------------------------
    // Channel 4 gain decode
    // ----------------------------------------------------------------
    // Registered so the amplifier sees a glitch-free code one cycle after
    // the register write
    always @(posedge core_clk) begin
        if (!rst_n) begin
            ch4_gain_sel_r <= 3'h0;
            ch4_gain_factor_r <= 8'h01;
        end else if (ce) begin
            ch4_gain_sel_r <= upper_channel_gain_r[`CCD_GAIN4_MSB:`CCD_GAIN4_LSB];
            ch4_gain_factor_r <= 8'h01 << upper_channel_gain_r[`CCD_GAIN4_MSB:`CCD_GAIN4_LSB];
        end
    end

    // ----------------------------------------------------------------
    // Threshold comparison per channel
    // ----------------------------------------------------------------
    assign threshold = {detect_threshold_hi_r, detect_threshold_lo_r};

    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi = gi + 1) begin : g_cmp
            // Signed compare: a result counts only when above the threshold
            assign exceed[gi] = $signed(ch_data[gi*SW +: SW]) > $signed(threshold);
        end
    endgenerate

    assign any_hit = |exceed;
    assign all_hit = &exceed;
    assign hit = detect_all_channels ? all_hit : any_hit;

    // ----------------------------------------------------------------
    // Chop settle and detect window
    // ----------------------------------------------------------------
    ccd_chop_delay u_chop (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ce(ce),
        .chop_en(chop_enable),
        .dly_sel(chop_settle_delay),
        .meas_req(meas_req),
        .mod_tick(mod_tick),
        .meas_start_r(meas_start),
        .settling_r(settling)
    );

    ccd_detect_win u_det (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ce(ce),
        .enable(detect_mode_enable),
        .len_sel(detect_window_length),
        .num_sel(detect_exceed_count),
        .conv_valid(conv_valid),
        .hit(hit),
        .detect_r(detect_pulse),
        .window_done_r(window_done),
        .exceed_cnt_r(exceed_cnt),
        .window_cnt_r()
    );

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    assign events = {meas_start & chop_enable, window_done, detect_pulse};

    // A new event in the clear cycle survives: set is applied after clear
    always @* begin
        irq_stat_nxt = irq_stat_r;
        if (wr_irq_clr) begin
            irq_stat_nxt = irq_stat_nxt & ~reg_wdata[2:0];
        end
        irq_stat_nxt = irq_stat_nxt | events;
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            irq_stat_r <= `CCD_RST_IRQ;
            irq_en_r <= `CCD_RST_IRQ;
        end else if (ce) begin
            irq_stat_r <= irq_stat_nxt;
            if (wr_irq_en) begin
                irq_en_r <= reg_wdata[2:0];
            end
        end
    end

    assign irq = |(irq_stat_r & irq_en_r);

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    always @* begin
        rdata_nxt = 16'h0000;
        case (reg_addr)
            `CCD_OFS_GAIN_HI: rdata_nxt = upper_channel_gain_r;
            `CCD_OFS_CFG: rdata_nxt = global_chop_detect_config_r;
            `CCD_OFS_THR_HI: rdata_nxt = detect_threshold_hi_r;
            `CCD_OFS_THR_LO: rdata_nxt = {detect_threshold_lo_r, 4'h0, dc_block_r};
            `CCD_OFS_IRQ_STAT: rdata_nxt = {13'h0000, irq_stat_r};
            `CCD_OFS_IRQ_EN: rdata_nxt = {13'h0000, irq_en_r};
            `CCD_OFS_DET_STAT: rdata_nxt = {5'h00, settling, detect_mode_enable, exceed_cnt};
            default: rdata_nxt = 16'h0000;
        endcase
    end

    // Data stands only in the cycle after the read strobe
    always @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata_r <= 16'h0000;
        end else if (ce) begin
            reg_rdata_r <= reg_rd ? rdata_nxt : 16'h0000;
        end
    end

endmodule // ccd_cfg_top

//--- dv/ccd_cfg_properties.sv
/*
 * Port-level checker for ccd_cfg_top, bound to every instance.
 * Assumes one core clock and a synchronous active-low reset.
 */
module ccd_cfg_properties (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic mod_tick,
    input wire logic meas_req,
    input wire logic conv_valid,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] ch4_gain_factor_r,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata_r,
    input wire logic [15:0] upper_channel_gain,
    input wire logic [2:0] ch4_gain_sel_r,
    input wire logic [2:0] detect_exceed_count,
    input wire logic [2:0] detect_window_length,
    input wire logic [3:0] chop_settle_delay,
    input wire logic chop_enable,
    input wire logic detect_all_channels,
    input wire logic detect_mode_enable,
    input wire logic meas_start,
    input wire logic settling,
    input wire logic detect_pulse,
    input wire logic window_done
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [16:0] tick_cnt_r;
    logic [12:0] cfg_v;
    assign cfg_v = {chop_settle_delay, chop_enable, detect_all_channels, detect_exceed_count,
                    detect_window_length, detect_mode_enable};
    // ----------------------------------------
    // Settle tick count, cleared while idle so each request starts fresh
    // ----------------------------------------
    always @(posedge core_clk) begin
        if (!rst_n || !settling)
            tick_cnt_r <= 17'h0;
        else if (ce && mod_tick)
            tick_cnt_r <= tick_cnt_r + 17'h1;
    end
    sequence s_chop_req;
        ce && meas_req && chop_enable && !settling && !meas_start;
    endsequence
    property p_cfg_reset;
        disable iff (1'b0) (!rst_n && ce) |=> cfg_v == 13'h0600;
    endproperty
    a_cfg_reset: assert property (p_cfg_reset) else $error("config fields off reset value");
    property p_cfg_write;
        ce && reg_wr && reg_addr == 8'h06 |=> cfg_v == $past(reg_wdata[12:0]);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config write not applied");
    property p_cfg_read;
        ce && reg_rd && reg_addr == 8'h06 |=> reg_rdata_r[12:0] == $past(cfg_v);
    endproperty
    a_cfg_read: assert property (p_cfg_read) else $error("config read data wrong");
    property p_gain_map;
        $stable(upper_channel_gain) [*3] |-> ch4_gain_sel_r == upper_channel_gain[2:0]
            && ch4_gain_factor_r == (8'h01 << upper_channel_gain[2:0]);
    endproperty
    a_gain_map: assert property (p_gain_map) else $error("gain factor does not match code");
    property p_chop_off;
        ce && meas_req && !chop_enable && !settling && !meas_start |=> meas_start;
    endproperty
    a_chop_off: assert property (p_chop_off) else $error("start late with chop off");
    property p_chop_on;
        s_chop_req |=> settling && !meas_start;
    endproperty
    a_chop_on: assert property (p_chop_on) else $error("settle did not begin");
    property p_chop_count;
        meas_start && $past(settling) |-> tick_cnt_r == (17'h2 << chop_settle_delay);
    endproperty
    a_chop_count: assert property (p_chop_count) else $error("settle tick count wrong");
    property p_mode_off;
        !detect_mode_enable |=> !detect_pulse && !window_done;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("detect activity with mode off");
    property p_det_cause;
        detect_pulse || window_done |-> $past(conv_valid && detect_mode_enable);
    endproperty
    a_det_cause: assert property (p_det_cause) else $error("detect event without conversion");
endmodule // ccd_cfg_properties

bind ccd_cfg_top ccd_cfg_properties u_props (.core_clk, .rst_n, .ce, .reg_wr, .reg_rd, .mod_tick,
    .meas_req, .conv_valid, .reg_addr, .ch4_gain_factor_r, .reg_wdata, .reg_rdata_r,
    .upper_channel_gain, .ch4_gain_sel_r, .detect_exceed_count, .detect_window_length,
    .chop_settle_delay, .chop_enable, .detect_all_channels, .detect_mode_enable, .meas_start,
    .settling, .detect_pulse, .window_done);

//--- dv/ccd_host_model.sv
/*
 * Host controller model: drives the register port of the block.
 * Assumes calls begin only after reset has been released.
 */
module ccd_host_model (
    input wire logic core_clk,
    input wire logic [15:0] reg_rdata_r,
    output logic [7:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // ----------------------------------------
    // Bus cycles
    // ----------------------------------------
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        // Reserved bits of gain and config words always go out as zero
        reg_wdata <= (a == 8'h05) ? (d & 16'h7777) : (a == 8'h06) ? (d & 16'h1fff) : d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [15:0] q);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 q = reg_rdata_r;
    endtask
endmodule // ccd_host_model

//--- dv/ccd_cfg_top_test.sv
/*
 * Self-checking bench for ccd_cfg_top: registers, chop settle, detect.
 * Assumes the bound checker and the host model beside the design.
 */
module ccd_cfg_top_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk, rst_n, ce, mod_tick, meas_req, conv_valid, reg_wr, reg_rd;
    logic [7:0] reg_addr, ch4_gain_factor_r;
    logic [15:0] reg_wdata, reg_rdata_r, upper_channel_gain, v;
    logic [191:0] ch_data;
    logic [2:0] ch4_gain_sel_r;
    logic [3:0] dc_block_sel;
    logic meas_start, settling, detect_pulse, window_done, irq, done;
    int i, n;
    int fails = 0;
    int samples_checked = 0;
    // Window length in conversions for each length code
    int wlen[8] = '{128, 256, 512, 768, 1280, 1792, 2560, 3584};
    ccd_cfg_top dut (.core_clk, .rst_n, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata_r, .mod_tick, .meas_req, .conv_valid, .ch_data, .ch4_gain_sel_r,
        .ch4_gain_factor_r, .upper_channel_gain, .chop_enable(), .chop_settle_delay(),
        .detect_all_channels(), .detect_exceed_count(), .detect_window_length(),
        .detect_mode_enable(), .dc_block_sel, .meas_start, .settling, .detect_pulse,
        .window_done, .irq);
    ccd_host_model host (.core_clk, .reg_rdata_r, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
    initial core_clk = 1'b0;
    always #2.5 core_clk = ~core_clk;
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Channels flagged in m sit just above a negative threshold, the rest below it
    task conv(input logic [7:0] m, input logic ed, input logic ew);
        int k;
        @(posedge core_clk);
        conv_valid <= 1'b1;
        for (k = 0; k < 8; k++)
            ch_data[24*k +: 24] <= m[k] ? 24'h000001 : 24'hfffff0;
        @(posedge core_clk);
        conv_valid <= 1'b0;
        #1 chk("detect", {15'h0, detect_pulse}, {15'h0, ed});
        chk("window", {15'h0, window_done}, {15'h0, ew});
    endtask
    task req;
        @(posedge core_clk);
        meas_req <= 1'b1;
        @(posedge core_clk);
        meas_req <= 1'b0;
    endtask
    initial begin
        #300000;
        fails++;
        results();
    end
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        mod_tick = 1'b0;
        meas_req = 1'b0;
        conv_valid = 1'b0;
        ch_data = 192'h0;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        host.rd(8'h06, v); chk("cfg", v, 16'h0600);
        host.rd(8'h05, v); chk("gain", v, 16'h0000);
        host.rd(8'h3f, v); chk("unmapped", v, 16'h0000);
        $display("test reset done");
        for (i = 0; i < 8; i++) begin
            host.wr(8'h05, 16'hfff8 | i[15:0]);
            repeat (3) @(posedge core_clk);
            #1 chk("gain_factor", {8'h0, ch4_gain_factor_r}, 16'h0001 << i);
            chk("gain_sel", {13'h0, ch4_gain_sel_r}, i[15:0]);
            chk("gain_reg", upper_channel_gain, 16'h7770 | i[15:0]);
            host.rd(8'h05, v); chk("gain", v, 16'h7770 | i[15:0]);
        end
        // A write while the clock enable is low must leave the register alone
        @(posedge core_clk);
        ce <= 1'b0;
        host.wr(8'h05, 16'h0003);
        ce <= 1'b1;
        host.rd(8'h05, v); chk("gain_frozen", v, 16'h7777);
        $display("test gain done");
        for (i = 0; i < 4; i++) begin
            host.wr(8'h06, 16'h0100 | (i[15:0] << 9));
            req();
            #1 chk("settling", {15'h0, settling}, 16'h0001);
            n = 0;
            done = 1'b0;
            while (!done && n < 100) begin
                @(posedge core_clk);
                mod_tick <= 1'b1;
                @(posedge core_clk);
                mod_tick <= 1'b0;
                n++;
                #1 done = (meas_start === 1'b1);
            end
            chk("chop_ticks", n[15:0], 16'h0002 << i);
            chk("settled", {15'h0, settling}, 16'h0000);
        end
        host.rd(8'h10, v); chk("irq_stat", v, 16'h0004);
        chk("irq_masked", {15'h0, irq}, 16'h0000);
        host.wr(8'h11, 16'h0004);
        #1 chk("irq_on", {15'h0, irq}, 16'h0001);
        host.wr(8'h12, 16'h0004);
        #1 chk("irq_off", {15'h0, irq}, 16'h0000);
        host.rd(8'h12, v); chk("irq_clr", v, 16'h0000);
        host.wr(8'h06, 16'h0000);
        req();
        #1 chk("start", {15'h0, meas_start}, 16'h0001);
        $display("test chop done");
        host.wr(8'h07, 16'hffff);
        host.wr(8'h08, 16'hfbf5);
        host.rd(8'h08, v); chk("thr_lo", v, 16'hfb05);
        chk("dc_block", {12'h0, dc_block_sel}, 16'h0005);
        host.wr(8'h06, 16'h0011);
        conv(8'h01, 1'b0, 1'b0);
        conv(8'h01, 1'b1, 1'b0);
        for (i = 2; i < 128; i++)
            conv(8'h01, 1'b0, i == 127);
        host.rd(8'h10, v); chk("irq_stat", v, 16'h0003);
        host.wr(8'h06, 16'h0081);
        conv(8'h7f, 1'b0, 1'b0);
        conv(8'hff, 1'b1, 1'b0);
        host.wr(8'h06, 16'h0000);
        conv(8'hff, 1'b0, 1'b0);
        host.wr(8'h06, 16'h0003);
        for (i = 0; i < 256; i++)
            conv(8'h00, 1'b0, i == 255);
        // Longer windows and larger exceedance targets, every conversion a hit
        for (i = 2; i < 8; i++) begin
            host.wr(8'h06, 16'h0001 | (i[15:0] << 1) | (i[15:0] << 4));
            for (n = 1; n <= wlen[i]; n++)
                conv(8'h01, n == (1 << i), n == wlen[i]);
        end
        $display("test detect done");
        results();
    end
endmodule // ccd_cfg_top_test
